// ---- hw/pcicfg_pkg.sv ----
// constants, field layouts and carrier types for the configuration header block
package pcicfg_pkg;

	// ****************************************************************
	// dword indexes of configuration space (byte offset / 4)
	// ****************************************************************
	localparam logic [5:0] DW_STATUS = 6'h01;
	localparam logic [5:0] DW_CLASS = 6'h02;
	localparam logic [5:0] DW_MISC = 6'h03;
	localparam logic [5:0] DW_BAR0 = 6'h04;
	localparam logic [5:0] DW_BAR1 = 6'h05;
	localparam logic [5:0] DW_IOBAR = 6'h06;
	localparam logic [5:0] DW_INITEN = 6'h10;
	localparam logic [5:0] DW_DECODE = 6'h12;

	// ****************************************************************
	// fixed values and reset values
	// ****************************************************************
	localparam logic [23:0] CLASS_CODE = 24'h00_0003;
	localparam logic [7:0] CACHE_LINE = 8'h00;
	localparam logic [7:0] LATENCY = 8'h00;
	localparam logic [7:0] SELF_TEST = 8'h00;
	localparam logic [6:0] HEADER_LOW = 7'h00;
	localparam logic [31:0] MEM0_LOW = 32'h0000_0000;
	localparam logic [31:0] MEM1_LOW = 32'h0000_0008;
	localparam logic [31:0] IO_LOW = 32'h0000_0001;
	localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;
	localparam logic [31:0] BAR0_LOCK = 32'h3FC0_0000;
	localparam logic [31:0] BAR1_LOCK = 32'h3800_0000;
	localparam logic [31:0] IO_LOCK = 32'h0000_0700;
	localparam logic IE_HW_RST = 1'b1;
	localparam logic IE_FIFO_RST = 1'b1;
	localparam logic IE_UNLOCK_RST = 1'b0;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int IE_HW_BIT = 8;
	localparam int IE_FIFO_BIT = 9;
	localparam int IE_UNLOCK_BIT = 10;
	localparam int IE_MULTI_BIT = 28;
	localparam int DEC_M0_LSB = 0;
	localparam int DEC_M1_LSB = 4;
	localparam int DEC_IO_LSB = 8;
	localparam int STRAP_FBB = 10;
	localparam int STRAP_MULTI = 11;

	// ****************************************************************
	// window size tables, indexed by size code
	// ****************************************************************
	localparam logic [31:0] MEM_MASK [0:8] = '{32'hF800_0000, 32'hF000_0000,
		32'hE000_0000, 32'hC000_0000, 32'hFC00_0000, 32'hFE00_0000,
		32'hFF00_0000, 32'hFF80_0000, 32'hFFC0_0000};
	localparam logic [31:0] IO_MASK [0:3] = '{32'hFFFF_FF00, 32'hFFFF_FE00,
		32'hFFFF_FC00, 32'hFFFF_F800};

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic rd;
		logic wr;
		logic [5:0] dw;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcicfg_req_t;

	typedef struct packed {
		logic dpe;
		logic sse;
		logic rma;
		logic rta;
		logic sta;
		logic dpr;
	} pcicfg_events_t;

	typedef struct packed {
		logic reg_win;
		logic fb_win;
		logic io_win;
	} pcicfg_hits_t;

endpackage : pcicfg_pkg

// ---- hw/pcicfg_bars.sv ----
// configuration header status, identity and base address registers
`timescale 1ns/100ps
module pcicfg_bars #(
	parameter logic [7:0] REVISION = 8'h5A, // arbitrary value
	parameter logic [1:0] DEVSEL_TIMING = 2'h0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire pcicfg_pkg::pcicfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire pcicfg_pkg::pcicfg_events_t bus_events,
	input wire logic [31:0] host_addr,
	input wire logic host_mem_cycle,
	input wire logic host_io_cycle,
	output pcicfg_pkg::pcicfg_hits_t window_hits,
	input wire logic [9:0] strap_pin,
	input wire logic fbb_strap,
	input wire logic multi_func_strap
);

	// ****************************************************************
	// functions
	// ****************************************************************
	// reserved codes fall back to the 128 MB layout of code 0
	function automatic logic [31:0] mem_mask(input logic [3:0] code);
		if (code > 4'h8) begin
			mem_mask = pcicfg_pkg::MEM_MASK[0];
		end else begin
			mem_mask = pcicfg_pkg::MEM_MASK[code];
		end
	endfunction : mem_mask

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	function automatic logic [31:0] bar_next(
		input logic [31:0] cur,
		input logic [31:0] dflt,
		input logic [31:0] lock,
		input pcicfg_pkg::pcicfg_req_t r,
		input logic unlock
	);
		logic [31:0] wm;
		wm = be_mask(r.be);
		if (!unlock) begin
			wm = wm & ~lock;
		end
		if (r.be == 4'hF && r.wdata == pcicfg_pkg::ALL_ONES) begin
			bar_next = dflt;
		end else begin
			bar_next = (cur & ~wm) | (r.wdata & wm);
		end
	endfunction : bar_next

	// ****************************************************************
	// strap capture
	// ****************************************************************
	logic [11:0] strap_s1;
	logic [11:0] strap_s2;
	logic [11:0] strap_cap;
	logic init_pend;

	always_ff @(posedge ref_clk) begin
		strap_s1 <= {multi_func_strap, fbb_strap, strap_pin};
		strap_s2 <= strap_s1;
	end

	// only moves while reset is held, so later pin noise never reaches the bases
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			strap_cap <= strap_s2;
		end
	end

	// first cycle after release loads the strap-derived defaults
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			init_pend <= 1'b1;
		end else begin
			init_pend <= 1'b0;
		end
	end

	// ****************************************************************
	// write decode
	// ****************************************************************
	logic wr_ok;
	logic wr_status;
	logic wr_bar0;
	logic wr_bar1;
	logic wr_iobar;
	logic wr_initen;
	logic wr_decode;

	assign wr_ok = cfg_req.wr && !init_pend;
	assign wr_status = wr_ok && cfg_req.dw == pcicfg_pkg::DW_STATUS && (cfg_req.be[3] || cfg_req.be[2]);
	assign wr_bar0 = wr_ok && cfg_req.dw == pcicfg_pkg::DW_BAR0;
	assign wr_bar1 = wr_ok && cfg_req.dw == pcicfg_pkg::DW_BAR1;
	assign wr_iobar = wr_ok && cfg_req.dw == pcicfg_pkg::DW_IOBAR;
	assign wr_initen = wr_ok && cfg_req.dw == pcicfg_pkg::DW_INITEN;
	assign wr_decode = wr_ok && cfg_req.dw == pcicfg_pkg::DW_DECODE;

	// ****************************************************************
	// status flags
	// ****************************************************************
	pcicfg_pkg::pcicfg_events_t flags;
	pcicfg_pkg::pcicfg_events_t clr;
	logic [15:0] status_word;

	always_comb begin
		clr = '0;
		if (wr_status) begin
			clr.dpe = 1'b1;
			if (cfg_req.be[3]) begin
				clr.sse = cfg_req.wdata[30];
				clr.rma = cfg_req.wdata[29];
				clr.rta = cfg_req.wdata[28];
				clr.sta = cfg_req.wdata[27];
				clr.dpr = cfg_req.wdata[24];
			end
		end
	end

	// an event in the clearing cycle survives the clear
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr) | bus_events;
		end
	end

	assign status_word = {flags.dpe, flags.sse, flags.rma, flags.rta, flags.sta,
		DEVSEL_TIMING, flags.dpr, strap_cap[pcicfg_pkg::STRAP_FBB], 7'h00};

	// ****************************************************************
	// control registers
	// ****************************************************************
	logic ie_hw;
	logic ie_fifo;
	logic ie_unlock;
	logic ie_multi;
	logic [9:0] dec;
	logic [31:0] init_word;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			ie_hw <= pcicfg_pkg::IE_HW_RST;
			ie_fifo <= pcicfg_pkg::IE_FIFO_RST;
			ie_unlock <= pcicfg_pkg::IE_UNLOCK_RST;
			ie_multi <= 1'b0;
		end else if (init_pend) begin
			ie_multi <= strap_cap[pcicfg_pkg::STRAP_MULTI];
		end else if (wr_initen) begin
			if (cfg_req.be[1]) begin
				ie_hw <= cfg_req.wdata[pcicfg_pkg::IE_HW_BIT];
				ie_fifo <= cfg_req.wdata[pcicfg_pkg::IE_FIFO_BIT];
				ie_unlock <= cfg_req.wdata[pcicfg_pkg::IE_UNLOCK_BIT];
			end
			if (cfg_req.be[3]) begin
				ie_multi <= cfg_req.wdata[pcicfg_pkg::IE_MULTI_BIT];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			dec <= '0;
		end else if (init_pend) begin
			dec <= strap_cap[9:0];
		end else if (wr_decode) begin
			if (cfg_req.be[0]) begin
				dec[7:0] <= cfg_req.wdata[7:0];
			end
			if (cfg_req.be[1]) begin
				dec[9:8] <= cfg_req.wdata[9:8];
			end
		end
	end

	always_comb begin
		init_word = '0;
		init_word[pcicfg_pkg::IE_HW_BIT] = ie_hw;
		init_word[pcicfg_pkg::IE_FIFO_BIT] = ie_fifo;
		init_word[pcicfg_pkg::IE_UNLOCK_BIT] = ie_unlock;
		init_word[pcicfg_pkg::IE_MULTI_BIT] = ie_multi;
	end

	// ****************************************************************
	// base address registers
	// ****************************************************************
	logic [31:0] bar0;
	logic [31:0] bar1;
	logic [31:0] iobar;
	logic [31:0] m0;
	logic [31:0] m1;
	logic [31:0] mio;
	logic [31:0] d0;
	logic [31:0] d1;
	logic [31:0] dio;

	assign m0 = mem_mask(dec[pcicfg_pkg::DEC_M0_LSB +: 4]);
	assign m1 = mem_mask(dec[pcicfg_pkg::DEC_M1_LSB +: 4]);
	assign mio = pcicfg_pkg::IO_MASK[dec[pcicfg_pkg::DEC_IO_LSB +: 2]];
	assign d0 = mem_mask(strap_cap[3:0]);
	assign d1 = mem_mask(strap_cap[7:4]);
	assign dio = pcicfg_pkg::IO_MASK[strap_cap[9:8]];

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bar0 <= '0;
		end else if (init_pend) begin
			bar0 <= d0;
		end else if (wr_bar0) begin
			bar0 <= bar_next(bar0, d0, pcicfg_pkg::BAR0_LOCK, cfg_req, ie_unlock);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bar1 <= '0;
		end else if (init_pend) begin
			bar1 <= d1;
		end else if (wr_bar1) begin
			bar1 <= bar_next(bar1, d1, pcicfg_pkg::BAR1_LOCK, cfg_req, ie_unlock);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			iobar <= '0;
		end else if (init_pend) begin
			iobar <= dio;
		end else if (wr_iobar) begin
			iobar <= bar_next(iobar, dio, pcicfg_pkg::IO_LOCK, cfg_req, ie_unlock);
		end
	end

	// ****************************************************************
	// configuration read path
	// ****************************************************************
	logic [31:0] rd_word;

	always_comb begin
		case (cfg_req.dw)
			pcicfg_pkg::DW_STATUS: begin
				rd_word = {status_word, 16'h0000};
			end
			pcicfg_pkg::DW_CLASS: begin
				rd_word = {pcicfg_pkg::CLASS_CODE, REVISION};
			end
			pcicfg_pkg::DW_MISC: begin
				rd_word = {pcicfg_pkg::SELF_TEST, ie_multi, pcicfg_pkg::HEADER_LOW,
					pcicfg_pkg::LATENCY, pcicfg_pkg::CACHE_LINE};
			end
			pcicfg_pkg::DW_BAR0: begin
				rd_word = (bar0 & m0) | pcicfg_pkg::MEM0_LOW;
			end
			pcicfg_pkg::DW_BAR1: begin
				rd_word = (bar1 & m1) | pcicfg_pkg::MEM1_LOW;
			end
			pcicfg_pkg::DW_IOBAR: begin
				rd_word = (iobar & mio) | pcicfg_pkg::IO_LOW;
			end
			pcicfg_pkg::DW_INITEN: begin
				rd_word = init_word;
			end
			pcicfg_pkg::DW_DECODE: begin
				rd_word = {22'h00_0000, dec};
			end
			default: begin
				rd_word = '0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cfg_rdata <= '0;
			cfg_ack <= 1'b0;
		end else begin
			cfg_ack <= cfg_req.rd || cfg_req.wr;
			cfg_rdata <= cfg_req.rd ? rd_word : '0;
		end
	end

	// ****************************************************************
	// host window decode
	// ****************************************************************
	// one cycle of latency buys a clean registered select
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			window_hits <= '0;
		end else begin
			window_hits.reg_win <= host_mem_cycle && !init_pend && ((host_addr ^ bar0) & m0) == '0;
			window_hits.fb_win <= host_mem_cycle && !init_pend && ((host_addr ^ bar1) & m1) == '0;
			window_hits.io_win <= host_io_cycle && !init_pend && ((host_addr ^ iobar) & mio) == '0;
		end
	end

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);

	a_dpe_sets: assert property (bus_events.dpe |=> status_word[15])
		else $error("parity event did not set status bit 15");

	a_dpe_clears: assert property (wr_status && !bus_events.dpe |=> !status_word[15])
		else $error("status write did not clear parity flag");

	a_abort_sets: assert property (bus_events.rta ##1 !(wr_status && cfg_req.be[3] && cfg_req.wdata[28])
		|=> status_word[12])
		else $error("received target abort lost");

	a_class_read: assert property (cfg_req.rd && cfg_req.dw == pcicfg_pkg::DW_CLASS
		|=> cfg_ack && cfg_rdata == {pcicfg_pkg::CLASS_CODE, REVISION})
		else $error("class or revision readback wrong");

	a_misc_zero: assert property (cfg_req.rd && cfg_req.dw == pcicfg_pkg::DW_MISC
		|=> cfg_rdata[22:0] == 23'h00_0000 && cfg_rdata[31:24] == 8'h00)
		else $error("cache, latency or self-test not zero");

	a_bar0_bit3: assert property (cfg_req.rd && cfg_req.dw == pcicfg_pkg::DW_BAR0
		|=> cfg_rdata[3:0] == 4'h0)
		else $error("register window low bits not zero");

	a_bar1_bit3: assert property (cfg_req.rd && cfg_req.dw == pcicfg_pkg::DW_BAR1
		|=> cfg_rdata[3:0] == 4'h8)
		else $error("frame buffer window low nibble not 8");

	a_probe_default: assert property (wr_bar0 && cfg_req.be == 4'hF && cfg_req.wdata == pcicfg_pkg::ALL_ONES
		|=> bar0 == mem_mask(strap_cap[3:0]))
		else $error("all-ones write did not restore default");

	a_lock_holds: assert property (wr_bar1 && !ie_unlock && cfg_req.wdata != pcicfg_pkg::ALL_ONES
		|=> (bar1 & pcicfg_pkg::BAR1_LOCK) == ($past(bar1) & pcicfg_pkg::BAR1_LOCK))
		else $error("locked base bits changed");

	a_fb_route: assert property (host_mem_cycle && !init_pend && ((host_addr ^ bar1) & m1) == '0
		|=> window_hits.fb_win)
		else $error("frame buffer access not routed");

	a_strap_init: assert property (init_pend |=> dec == strap_cap[9:0] && iobar == dio)
		else $error("decode fields not loaded from straps");

	a_strap_hold: assert property ($past(nrst) |-> $stable(strap_cap))
		else $error("strap capture moved after reset");

	c_bar_probe: cover property (wr_bar0 && cfg_req.wdata == pcicfg_pkg::ALL_ONES ##2 cfg_req.rd);
	c_fb_hit: cover property (window_hits.fb_win);
	c_io_hit: cover property (window_hits.io_win);
	c_set_clear: cover property (bus_events.dpe && wr_status);

endmodule : pcicfg_bars

// ---- tb/pcicfg_host.sv ----
// host bridge model that issues configuration reads and writes
`timescale 1ns/100ps
module pcicfg_host (
	input wire logic ref_clk,
	output pcicfg_pkg::pcicfg_req_t cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack
);
	// ********
	// request driver
	// ********
	initial begin
		cfg_req = '0;
	end

	// one pulse per request; the answer stands one cycle, so it is taken at the next falling edge
	task automatic access(input logic rd, input logic [5:0] dw, input logic [3:0] be,
		input logic [31:0] wdata, output logic [31:0] rdata, output logic ack);
		@(negedge ref_clk);
		cfg_req.rd = rd;
		cfg_req.wr = ~rd;
		cfg_req.dw = dw;
		cfg_req.be = be;
		cfg_req.wdata = wdata;
		@(negedge ref_clk);
		ack = cfg_ack;
		rdata = cfg_rdata;
		// released lines show the inverse, so a stale copy can never pass for a request
		cfg_req = {2'b00, ~dw, ~be, ~wdata};
	endtask : access
endmodule : pcicfg_host

// ---- tb/pcicfg_bars_tb.sv ----
// self-checking bench for the configuration header block
`timescale 1ns/100ps
module pcicfg_bars_tb;
	// ********
	// design, host bridge, bench state
	// ********
	localparam logic [7:0] REV = 8'hA7; // arbitrary value
	logic ref_clk;
	logic nrst;
	pcicfg_pkg::pcicfg_req_t cfg_req;
	logic [31:0] cfg_rdata;
	logic cfg_ack;
	pcicfg_pkg::pcicfg_events_t bus_events;
	logic [31:0] host_addr;
	logic host_mem_cycle;
	logic host_io_cycle;
	pcicfg_pkg::pcicfg_hits_t window_hits;
	logic [9:0] strap_pin;
	logic fbb_strap;
	logic multi_func_strap;
	int bad_count;
	int n_compared;
	logic [31:0] mk [3];
	logic [31:0] lk [3];
	logic [31:0] lo [3];
	logic [31:0] bv [3];
	logic [31:0] dm [3];
	logic [5:0] bdw [3];
	logic fb;
	logic mf;

	pcicfg_bars #(.REVISION(REV), .DEVSEL_TIMING(2'h0)) uut (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack),
		.bus_events(bus_events),
		.host_addr(host_addr),
		.host_mem_cycle(host_mem_cycle),
		.host_io_cycle(host_io_cycle),
		.window_hits(window_hits),
		.strap_pin(strap_pin),
		.fbb_strap(fbb_strap),
		.multi_func_strap(multi_func_strap)
	);

	pcicfg_host host (
		.ref_clk(ref_clk),
		.cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata),
		.cfg_ack(cfg_ack)
	);

	always #2 ref_clk = ~ref_clk;

	// ********
	// expectations, comparisons, bus cycles
	// ********
	// reserved size codes fold onto the 128 MB window of code 0
	function automatic logic [31:0] mm(input logic [3:0] c);
		return (c > 4'h8) ? pcicfg_pkg::MEM_MASK[0] : pcicfg_pkg::MEM_MASK[c];
	endfunction : mm

	task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk_word

	task automatic chk_hits(input string what, input pcicfg_pkg::pcicfg_hits_t exp,
		input pcicfg_pkg::pcicfg_hits_t got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask : chk_hits

	task automatic cfg_wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] d);
		logic [31:0] r;
		logic a;
		host.access(1'b0, dw, be, d, r, a);
		chk_word("write ack", 32'h1, {31'h0, a});
	endtask : cfg_wr

	task automatic cfg_rd(input string what, input logic [5:0] dw, input logic [31:0] exp);
		logic [31:0] r;
		logic a;
		host.access(1'b1, dw, 4'hF, 32'h0, r, a);
		chk_word("read ack", 32'h1, {31'h0, a});
		chk_word(what, exp, r);
	endtask : cfg_rd

	task automatic do_reset(input logic [9:0] s, input logic f, input logic m);
		@(negedge ref_clk);
		nrst = 1'b0;
		strap_pin = s;
		fbb_strap = f;
		multi_func_strap = m;
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		@(negedge ref_clk);
		// pins move after capture; the registers must keep the captured codes
		strap_pin = ~s;
		fbb_strap = ~f;
		multi_func_strap = ~m;
		fb = f;
		mf = m;
		mk = '{mm(s[3:0]), mm(s[7:4]), pcicfg_pkg::IO_MASK[s[9:8]]};
		bv = mk;
	endtask : do_reset

	task automatic test_done();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : test_done

	// ********
	// watchdog, about sixty times the expected run
	// ********
	initial begin
		#200000;
		bad_count++;
		test_done();
	end

	// ********
	// scenarios
	// ********
	initial begin
		logic [9:0] c;
		logic [31:0] w;
		logic [31:0] a;
		logic [31:0] st;
		logic [31:0] ie;
		logic [31:0] fl;
		int i;
		pcicfg_pkg::pcicfg_hits_t eh;
		ref_clk = 1'b0;
		nrst = 1'b0;
		bus_events = '0;
		host_addr = 32'h0;
		host_mem_cycle = 1'b0;
		host_io_cycle = 1'b0;
		strap_pin = 10'h0;
		fbb_strap = 1'b0;
		multi_func_strap = 1'b0;
		bad_count = 0;
		n_compared = 0;
		lk = '{pcicfg_pkg::BAR0_LOCK, pcicfg_pkg::BAR1_LOCK, pcicfg_pkg::IO_LOCK};
		lo = '{pcicfg_pkg::MEM0_LOW, pcicfg_pkg::MEM1_LOW, pcicfg_pkg::IO_LOW};
		bdw = '{pcicfg_pkg::DW_BAR0, pcicfg_pkg::DW_BAR1, pcicfg_pkg::DW_IOBAR};
		void'($urandom(88));
		for (int k = 0; k < 4; k++) begin
			c = {2'($urandom_range(3, 0)), 4'($urandom_range(8, 0)), 4'($urandom_range(8, 0))};
			if (k == 0) c = {2'h2, 4'h8, 4'h8};
			if (k == 1) c = 10'h0;
			do_reset(c, 1'($urandom), 1'($urandom));
			st = {8'h0, fb, 23'h0};
			ie = {3'h0, mf, 28'h000_0300};
			cfg_rd("status", pcicfg_pkg::DW_STATUS, st);
			cfg_rd("register base", bdw[0], mk[0]);
			cfg_rd("frame buffer base", bdw[1], mk[1] | lo[1]);
			cfg_rd("io base", bdw[2], mk[2] | lo[2]);
			cfg_rd("decode control", pcicfg_pkg::DW_DECODE, {22'h0, c});
			cfg_rd("init unlock", pcicfg_pkg::DW_INITEN, ie);
			cfg_wr(pcicfg_pkg::DW_CLASS, 4'hF, pcicfg_pkg::ALL_ONES);
			cfg_wr(pcicfg_pkg::DW_MISC, 4'hF, pcicfg_pkg::ALL_ONES);
			cfg_rd("class", pcicfg_pkg::DW_CLASS, {pcicfg_pkg::CLASS_CODE, REV});
			cfg_rd("misc", pcicfg_pkg::DW_MISC, {8'h0, mf, 23'h0});
			cfg_wr(6'h20, 4'hF, pcicfg_pkg::ALL_ONES);
			cfg_rd("unmapped", 6'h20, 32'h0);
			for (int e = 0; e < 6; e++) begin
				fl = st | (32'h1 << ((e < 5) ? 31 - e : 24));
				@(negedge ref_clk);
				bus_events = pcicfg_pkg::pcicfg_events_t'(6'h20 >> e);
				@(negedge ref_clk);
				bus_events = '0;
				cfg_rd("status flag", pcicfg_pkg::DW_STATUS, fl);
				// a fresh event in the clearing cycle must win over the clear
				fork
					cfg_wr(pcicfg_pkg::DW_STATUS, 4'hC, 32'hFFFF_0000);
					begin
						@(negedge ref_clk);
						bus_events = pcicfg_pkg::pcicfg_events_t'(6'h20 >> e);
						@(negedge ref_clk);
						bus_events = '0;
					end
				join
				cfg_rd("set beats clear", pcicfg_pkg::DW_STATUS, fl);
				cfg_wr(pcicfg_pkg::DW_STATUS, 4'hC, 32'hFFFF_0000);
				cfg_rd("status cleared", pcicfg_pkg::DW_STATUS, st);
			end
			// a locked write may only move the bits outside the lock field
			for (i = 0; i < 3; i++) begin
				w = $urandom;
				cfg_wr(bdw[i], 4'hF, w);
				cfg_rd("locked base", bdw[i], (((w & ~lk[i]) | lk[i]) & mk[i]) | lo[i]);
				cfg_wr(pcicfg_pkg::DW_INITEN, 4'hF, ie | 32'h400);
				w = $urandom;
				cfg_wr(bdw[i], 4'hF, w);
				bv[i] = w & mk[i];
				cfg_rd("unlocked base", bdw[i], bv[i] | lo[i]);
				cfg_wr(pcicfg_pkg::DW_INITEN, 4'hF, ie);
			end
			repeat (24) begin
				i = $urandom_range(2, 0);
				a = $urandom;
				if ($urandom_range(1, 0) == 1) a = bv[i] | (a & ~mk[i]);
				@(negedge ref_clk);
				host_addr = a;
				host_mem_cycle = (i != 2);
				host_io_cycle = (i == 2);
				@(negedge ref_clk);
				host_mem_cycle = 1'b0;
				host_io_cycle = 1'b0;
				host_addr = ~a;
				eh.reg_win = (i != 2) && ((a & mk[0]) == bv[0]);
				eh.fb_win = (i != 2) && ((a & mk[1]) == bv[1]);
				eh.io_win = (i == 2) && ((a & mk[2]) == bv[2]);
				chk_hits("window hits", eh, window_hits);
			end
			// new decode sizes, then an all-ones probe of each base, which restores its strap default
			c = {2'($urandom_range(3, 0)), 4'($urandom_range(15, 0)), 4'($urandom_range(15, 0))};
			dm = '{mm(c[3:0]), mm(c[7:4]), pcicfg_pkg::IO_MASK[c[9:8]]};
			cfg_wr(pcicfg_pkg::DW_DECODE, 4'hF, {22'h0, c});
			cfg_rd("decode control", pcicfg_pkg::DW_DECODE, {22'h0, c});
			for (i = 0; i < 3; i++) begin
				cfg_wr(bdw[i], 4'hF, pcicfg_pkg::ALL_ONES);
				cfg_rd("size probe", bdw[i], (mk[i] & dm[i]) | lo[i]);
			end
		end
		test_done();
	end
endmodule : pcicfg_bars_tb
